// *** shared/ewps_defines.svh ***
// constants of the eeprom write-protect and status block
`ifndef EWPS_DEFINES_SVH
`define EWPS_DEFINES_SVH
`define EWPS_BUSY_BIT 0
`define EWPS_LATCH_BIT 1
`define EWPS_BPL_BIT 2
`define EWPS_BPH_BIT 3
`define EWPS_OP_CLEAR_WRITE_LATCH_CMD 8'h04
`define EWPS_OP_SET_WRITE_LATCH_CMD 8'h06
`define EWPS_OP_STATUS_READ_CMD 8'h05
`define EWPS_OP_STATUS_WRITE_CMD 8'h01
`define EWPS_OP_READ 8'h03
`define EWPS_OP_WRITE 8'h02
`define EWPS_OP_MASK 8'hf7
`define EWPS_PROT_Q_BASE 9'h180
`define EWPS_PROT_H_BASE 9'h100
`define EWPS_WRITE_TIME_US 5000
`define EWPS_CLK_MHZ 20
`define EWPS_WRITE_CYC (`EWPS_WRITE_TIME_US * `EWPS_CLK_MHZ)
`endif

// *** shared/ewps_pkg.sv ***
// types of the eeprom write-protect and status block
`default_nettype none
package ewps_pkg;
    typedef enum logic [2:0] {
        EWPS_IDLE, EWPS_CMD, EWPS_ADDR, EWPS_DATA, EWPS_STOUT, EWPS_SKIP
    } ewps_phase_t;
endpackage : ewps_pkg
`default_nettype wire

// *** sim/eeprom_write_protect_status_tb_top.sv ***
// self-checking bench for the write-protect and status block
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_protect_status_tb_top;
    localparam int WCYC = 300;
    typedef struct packed {
        logic [23:0] d;
        logic [4:0] n;
        logic wp;
        logic l;
        logic b;
        logic [1:0] pc;
        logic [1:0] bp;
    } ewps_row_t;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_wp_n = 1'b1;
    logic sel_n, sck, sdi, sdo, sdo_oe, busy, latch, pulse;
    logic [1:0] bp;
    logic [8:0] paddr, paddr_q;
    logic [7:0] pdata, pdata_q, rx;
    int err_total = 0;
    int compares = 0;
    int pulses = 0;
    int i;
    // rows: frame, bit count, protect pin, latch, busy, pulses, protect
    ewps_row_t rows [16] = '{
        '{24'h000006, 5'h08, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0},
        '{24'h000004, 5'h08, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0},
        '{24'h00000e, 5'h08, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0},
        '{24'h0a2355, 5'h18, 1'b1, 1'b0, 1'b1, 2'h1, 2'h0},
        '{24'h000003, 5'h07, 1'b1, 1'b0, 1'b0, 2'h1, 2'h0},
        '{24'h000006, 5'h08, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0},
        '{24'h0511aa, 5'h17, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0},
        '{24'h0001fc, 5'h10, 1'b1, 1'b0, 1'b1, 2'h1, 2'h3},
        '{24'h000006, 5'h08, 1'b1, 1'b1, 1'b0, 2'h1, 2'h3},
        '{24'h021077, 5'h18, 1'b1, 1'b1, 1'b0, 2'h1, 2'h3},
        '{24'h000104, 5'h10, 1'b1, 1'b0, 1'b1, 2'h1, 2'h1},
        '{24'h000006, 5'h08, 1'b1, 1'b1, 1'b0, 2'h1, 2'h1},
        '{24'h0a8033, 5'h18, 1'b1, 1'b1, 1'b0, 2'h1, 2'h1},
        '{24'h0a7f33, 5'h18, 1'b1, 1'b0, 1'b1, 2'h2, 2'h1},
        '{24'h000006, 5'h08, 1'b0, 1'b0, 1'b0, 2'h2, 2'h1},
        '{24'h000006, 5'h08, 1'b1, 1'b1, 1'b0, 2'h2, 2'h1}};

    ewps_core #(.WRITE_CYC(WCYC), .BP_INIT(2'h0)) i_dut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_sel_n(sel_n),
        .i_sck(sck), .i_sdi(sdi), .i_wp_n(i_wp_n), .o_sdo(sdo),
        .o_sdo_oe(sdo_oe), .o_busy(busy), .o_latch(latch),
        .o_block_protect(bp), .o_prog_pulse(pulse), .o_prog_addr(paddr),
        .o_prog_data(pdata));

    ewps_host_model i_host (
        .i_clk_sys(i_clk_sys), .i_sdo(sdo), .i_sdo_oe(sdo_oe),
        .o_sel_n(sel_n), .o_sck(sck), .o_sdi(sdi));

    // clock, and a record of each programmed byte
    always #25 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys)
    begin
        if (pulse === 1'b1)
        begin
            pulses <= pulses + 1;
            paddr_q <= paddr;
            pdata_q <= pdata;
        end
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                       input string what);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // bounded wait for the internal write to finish
    task automatic wait_idle();
        int k;
        for (k = 0; k < WCYC + 50 && busy !== 1'b0; k++)
            @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        #1;
    endtask : wait_idle

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // watchdog sized well above the expected run of about 0.3 ms
    initial
    begin
        #2000000;
        err_total++;
        end_sim();
    end

    initial
    begin
        repeat (5) @(posedge i_clk_sys);
        #1;
        chk({7'h00, latch, busy}, 9'h000, "reset flags");
        chk({8'h00, sdo_oe}, 9'h000, "reset output");
        i_sys_rst = 1'b0;
        for (i = 0; i < 16; i++)
        begin
            i_wp_n = rows[i].wp;
            i_host.frame(rows[i].d, int'(rows[i].n), rx);
            chk({8'h00, latch}, {8'h00, rows[i].l},
                "latch");
            chk({8'h00, busy}, {8'h00, rows[i].b},
                "busy");
            wait_idle();
            chk({8'h00, busy}, 9'h000, "idle");
            chk({7'h00, bp}, {7'h00, rows[i].bp}, "protect");
            chk(9'(pulses), 9'(rows[i].pc), "pulses");
            i_host.frame(24'h000500, 16, rx);
            chk({1'b0, rx}, {5'h00, rows[i].bp, rows[i].l, 1'b0},
                "status");
            $display("row %0d done", i);
        end
        chk(paddr_q, 9'h17f, "addr");
        chk({1'b0, pdata_q}, 9'h033, "data");
        // status read and protect pin fall during a running write
        i_host.frame(24'h000006, 8, rx);
        i_host.frame(24'h0240a5, 24, rx);
        i_wp_n = 1'b0;
        i_host.frame(24'h000500, 16, rx);
        chk({1'b0, rx}, 9'h005, "status busy");
        wait_idle();
        chk(9'(pulses), 9'h003, "write kept");
        chk(paddr_q, 9'h040, "addr kept");
        chk({1'b0, pdata_q}, 9'h0a5, "data kept");
        i_wp_n = 1'b1;
        $display("busy test done");
        // second reset mid-run; the block must answer again afterwards
        i_host.frame(24'h000006, 8, rx);
        i_sys_rst = 1'b1;
        @(posedge i_clk_sys);
        #1;
        chk({7'h00, latch, sdo_oe}, 9'h000, "reset again");
        i_sys_rst = 1'b0;
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk({7'h00, latch, busy}, 9'h000, "after release");
        i_host.frame(24'h000006, 8, rx);
        chk({8'h00, latch}, 9'h001, "latch again");
        $display("reset test done");
        end_sim();
    end
endmodule : eeprom_write_protect_status_tb_top
`default_nettype wire

// *** sim/ewps_host_model.sv ***
// host-side serial master model driving select, clock and data pins
`timescale 1ns/10ps
`default_nettype none
module ewps_host_model (
    input wire logic i_clk_sys,
    input wire logic i_sdo,
    input wire logic i_sdo_oe,
    output logic o_sel_n,
    output logic o_sck,
    output logic o_sdi
);
    // idle: deselected, clock parked low between frames
    initial
    begin
        o_sel_n = 1'b1;
        o_sck = 1'b0;
        o_sdi = 1'b0;
    end

    // advance n system clocks, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick

    // one frame of nbits, msb first; rx keeps the last eight bits read
    task automatic frame(input logic [23:0] d, input int nbits,
                         output logic [7:0] rx);
        int i;
        rx = 8'h00;
        tick(1);
        o_sel_n = 1'b0;
        for (i = nbits - 1; i >= 0; i--)
        begin
            o_sdi = d[i];
            tick(4);
            o_sck = 1'b1;
            tick(4);
            // an undriven output must never pass for data
            rx = {rx[6:0], i_sdo_oe ? i_sdo : 1'bx};
            o_sck = 1'b0;
        end
        tick(4);
        o_sel_n = 1'b1;
        o_sdi = ~o_sdi; // released line shows no stale level
        tick(8);
    endtask : frame
endmodule : ewps_host_model
`default_nettype wire

// *** src/ewps_core.sv ***
// write-protect, latch and status logic of a serial eeprom front end
// Behaviour
// - no write starts without latch set
// - enable command sets, disable command clears latch
// - latch cleared on reset, writes, protect low
// - status read answered even while busy
// - status: busy b0, latch b1, protect b3:2
// - busy flag high only during internal write
// - latch flag mirrors latch; latch commands act even while busy
// - protect bits reset to BP_INIT, changed by status write
// - protect codes: none, quarter, half, all
// - protect pin low or latch clear blocks writes
// - array access ignored while writing
// - write starts only on exact select rise
// - power-on: idle, deselected, latch clear, output off
// - select fall needed before first command
// - command byte codes, bit 3 ignored, msb first
// - latch set only on select rise after 8 bits
// - running write not aborted by protect pin
`timescale 1ns/10ps
`default_nettype none
`include "ewps_defines.svh"
module ewps_core #(
    parameter int WRITE_CYC = `EWPS_WRITE_CYC,
    parameter logic [1:0] BP_INIT = 2'h0
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_sel_n,
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire logic i_wp_n,
    output logic o_sdo,
    output logic o_sdo_oe,
    output logic o_busy,
    output logic o_latch,
    output logic [1:0] o_block_protect,
    output logic o_prog_pulse,
    output logic [8:0] o_prog_addr,
    output logic [7:0] o_prog_data
);
    typedef struct packed {
        ewps_pkg::ewps_phase_t phase;
        logic armed;
        logic [7:0] cmd;
        logic [7:0] shift;
        logic [3:0] bits;
        logic [8:0] addr;
        logic [7:0] data;
        logic data_full;
        logic [7:0] st_out;
        logic sck_d;
        logic sel_d;
        logic latch;
        logic busy;
        logic [1:0] bp;
        logic [1:0] bp_pend;
        logic st_write;
        logic [31:0] cnt;
        logic sdo;
        logic sdo_oe;
        logic prog;
        logic [8:0] prog_addr;
        logic [7:0] prog_data;
    } ewps_st_t;

    ewps_st_t st_ff;
    ewps_st_t nxt_st;
    logic [3:0] pins;
    logic sel_n;
    logic sck;
    logic sdi;
    logic wp_n;
    logic rise;
    logic fall;
    logic sel_up;
    logic sel_dn;
    logic prot_hit;
    logic [7:0] status;

    // pins cross in through two flops; select idles high
    ewps_sync #(.W(4), .INIT(4'h9)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_async({i_sel_n, i_sck, i_sdi, i_wp_n}),
        .o_sync(pins)
    );
    assign {sel_n, sck, sdi, wp_n} = pins;

    // edges come from the synced pins against last cycle's copies
    assign rise = sck & ~st_ff.sck_d & ~sel_n;
    assign fall = ~sck & st_ff.sck_d & ~sel_n;
    assign sel_up = sel_n & ~st_ff.sel_d;
    assign sel_dn = ~sel_n & st_ff.sel_d;

    // address decode of the protected range
    always_comb
    begin
        unique case (st_ff.bp)
            2'b00: prot_hit = 1'b0;
            2'b01: prot_hit = st_ff.addr >= `EWPS_PROT_Q_BASE;
            2'b10: prot_hit = st_ff.addr >= `EWPS_PROT_H_BASE;
            2'b11: prot_hit = 1'b1;
        endcase
    end

    // upper bits tied low so stray writes never show
    assign status = {4'h0, st_ff.bp, st_ff.latch, st_ff.busy};

    // main sequencer: shifts on sck rise, acts on select rise
    always_comb
    begin
        logic [7:0] sh;
        logic [7:0] op;
        sh = {st_ff.shift[6:0], sdi};
        op = st_ff.cmd & `EWPS_OP_MASK;
        nxt_st = st_ff;
        nxt_st.sck_d = sck;
        nxt_st.sel_d = sel_n;
        nxt_st.prog = 1'b0;
        // internal write timer; protect pin cannot stop it
        if (st_ff.busy)
        begin
            if (st_ff.cnt == 32'(WRITE_CYC - 1))
            begin
                nxt_st.busy = 1'b0;
                nxt_st.latch = 1'b0;
                nxt_st.cnt = 32'h0;
                if (st_ff.st_write)
                    nxt_st.bp = st_ff.bp_pend;
                else
                    nxt_st.prog = 1'b1;
            end
            else
                nxt_st.cnt = st_ff.cnt + 32'h1;
        end
        if (sel_dn)
        begin
            nxt_st.armed = 1'b1;
            nxt_st.phase = ewps_pkg::EWPS_CMD;
            nxt_st.bits = 4'h0;
            nxt_st.data_full = 1'b0;
        end
        else if (sel_up)
        begin
            nxt_st.phase = ewps_pkg::EWPS_IDLE;
            nxt_st.sdo_oe = 1'b0;
            // command takes effect only on a rise at a byte boundary
            if (st_ff.armed && st_ff.bits == 4'h0)
            begin
                if (st_ff.phase == ewps_pkg::EWPS_ADDR)
                begin
                    if (op == `EWPS_OP_SET_WRITE_LATCH_CMD)
                        nxt_st.latch = 1'b1;
                    else if (op == `EWPS_OP_CLEAR_WRITE_LATCH_CMD)
                        nxt_st.latch = 1'b0;
                end
                else if (st_ff.phase == ewps_pkg::EWPS_DATA &&
                    st_ff.data_full && !st_ff.busy && st_ff.latch &&
                    wp_n)
                begin
                    if (op == `EWPS_OP_STATUS_WRITE_CMD)
                    begin
                        nxt_st.busy = 1'b1;
                        nxt_st.st_write = 1'b1;
                        nxt_st.bp_pend = st_ff.data[3:2];
                        nxt_st.latch = 1'b0;
                    end
                    else if (!prot_hit)
                    begin
                        nxt_st.busy = 1'b1;
                        nxt_st.st_write = 1'b0;
                        nxt_st.prog_addr = st_ff.addr;
                        nxt_st.prog_data = st_ff.data;
                        nxt_st.latch = 1'b0;
                    end
                end
            end
        end
        else if (rise && st_ff.armed)
        begin
            nxt_st.shift = sh;
            nxt_st.bits = st_ff.bits + 4'h1;
            if (st_ff.bits == 4'h7)
            begin
                nxt_st.bits = 4'h0;
                unique case (st_ff.phase)
                    ewps_pkg::EWPS_IDLE: nxt_st.phase = ewps_pkg::EWPS_SKIP;
                    ewps_pkg::EWPS_CMD:
                    begin
                        nxt_st.cmd = sh;
                        nxt_st.addr = {sh[3], 8'h00};
                        if ((sh & `EWPS_OP_MASK) == `EWPS_OP_STATUS_READ_CMD)
                        begin
                            nxt_st.phase = ewps_pkg::EWPS_STOUT;
                            nxt_st.st_out = status;
                        end
                        else if ((sh & `EWPS_OP_MASK) == `EWPS_OP_STATUS_WRITE_CMD)
                            nxt_st.phase = ewps_pkg::EWPS_DATA;
                        // other commands all pass the address phase
                        else
                            nxt_st.phase = ewps_pkg::EWPS_ADDR;
                    end
                    ewps_pkg::EWPS_ADDR:
                    begin
                        nxt_st.addr = {st_ff.addr[8], sh};
                        if ((st_ff.cmd & `EWPS_OP_MASK) == `EWPS_OP_WRITE)
                        begin
                            nxt_st.phase = ewps_pkg::EWPS_DATA;
                            nxt_st.cmd = `EWPS_OP_WRITE;
                        end
                        else
                            nxt_st.phase = ewps_pkg::EWPS_SKIP;
                    end
                    ewps_pkg::EWPS_DATA:
                    begin
                        nxt_st.data = sh;
                        nxt_st.data_full = 1'b1;
                    end
                    ewps_pkg::EWPS_STOUT: nxt_st.st_out = status;
                    ewps_pkg::EWPS_SKIP: nxt_st.phase = ewps_pkg::EWPS_SKIP;
                    default: nxt_st.phase = ewps_pkg::EWPS_IDLE;
                endcase
            end
        end
        else if (fall && st_ff.phase == ewps_pkg::EWPS_STOUT)
        begin
            // output changes after falling edge, msb first
            nxt_st.sdo = st_ff.st_out[7];
            nxt_st.sdo_oe = 1'b1;
            nxt_st.st_out = {st_ff.st_out[6:0], 1'b0};
        end
        // protect pin low drops the latch at any time
        if (!wp_n)
            nxt_st.latch = 1'b0;
    end

    // power-on values; protect bits load the BP_INIT parameter
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_ff <= '0;
            st_ff.sck_d <= 1'b0;
            st_ff.sel_d <= 1'b1; // select idles high: no false fall
            st_ff.bp <= BP_INIT;
        end
        else
            st_ff <= nxt_st;
    end

    assign o_sdo = st_ff.sdo;
    assign o_sdo_oe = st_ff.sdo_oe;
    assign o_busy = st_ff.busy;
    assign o_latch = st_ff.latch;
    assign o_block_protect = st_ff.bp;
    assign o_prog_pulse = st_ff.prog;
    assign o_prog_addr = st_ff.prog_addr;
    assign o_prog_data = st_ff.prog_data;

    AST_NO_WRITE_WITHOUT_LATCH: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $rose(st_ff.busy) |-> $past(st_ff.latch))
        else $error("write began with latch clear");
    AST_WP_CLEARS_LATCH: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) !wp_n |=> !st_ff.latch)
        else $error("latch set while protect pin low");
    AST_END_CLEARS_LATCH: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $fell(st_ff.busy) |-> !st_ff.latch)
        else $error("latch survived write end");
    AST_UNUSED_ZERO: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $rose(st_ff.sdo_oe) |-> !st_ff.sdo)
        else $error("unused status bit shifted out nonzero");
    AST_BP_STABLE: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        $changed(st_ff.bp) |-> $past(st_ff.busy) && $past(st_ff.st_write))
        else $error("protect bits changed outside status write");
    AST_BUSY_HOLDS: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $rose(st_ff.busy) |-> st_ff.busy [*8])
        else $error("write cycle cut short");
    AST_LATCH_ON_RISE: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $rose(st_ff.latch) |-> $past(sel_up))
        else $error("latch set without select rise");
    AST_IDLE_OFF: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) sel_n |=> !st_ff.sdo_oe)
        else $error("output driven while deselected");
    // sequencer checks: starts, refusals, the running timer and its end pulse
    AST_BUSY_ON_RISE: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $rose(st_ff.busy) |-> $past(sel_up))
        else $error("write began without select rise");
    AST_BUSY_NEEDS_PIN: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) $rose(st_ff.busy) |-> $past(wp_n))
        else $error("write began with protect pin low");
    AST_PROT_RANGE: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        $rose(st_ff.busy) && !st_ff.st_write |-> !$past(prot_hit))
        else $error("write began in a protected block");
    AST_TIMER_STEADY: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) st_ff.busy && $past(st_ff.busy) |->
        st_ff.cnt == $past(st_ff.cnt) + 32'h1)
        else $error("running write restarted");
    AST_PULSE_AT_END: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) st_ff.prog |-> $fell(st_ff.busy))
        else $error("program pulse outside write end");
endmodule : ewps_core
`default_nettype wire

// *** src/ewps_sync.sv ***
// two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/10ps
`default_nettype none
module ewps_sync #(
    parameter int W = 4,
    parameter logic [3:0] INIT = 4'h0
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ewps_sync_st_t;
    ewps_sync_st_t st_ff;
    ewps_sync_st_t nxt_st;

    // first stage feeds only the second stage
    always_comb
    begin
        nxt_st.s1 = i_async;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_ff.s1 <= INIT[W-1:0];
            st_ff.s2 <= INIT[W-1:0];
        end
        else
            st_ff <= nxt_st;
    end

    assign o_sync = st_ff.s2;
endmodule : ewps_sync
`default_nettype wire
